// ==== verilog/mirc_map.vh ====
/*
  Register map, field positions and reset values of the interrupt request controller.
  Assumes APB with 32-bit data; each 8-bit register sits in the low bits of one word.
*/
`ifndef MIRC_MAP_VH
`define MIRC_MAP_VH

// ----------------------------------------------------------------------------
// byte addresses
// ----------------------------------------------------------------------------
`define MIRC_A_EDGE      8'h00
`define MIRC_A_CTRL_A    8'h04
`define MIRC_A_CTRL_B    8'h08
`define MIRC_A_CTRL_C    8'h0C
`define MIRC_A_GRP_A     8'h10
`define MIRC_A_GRP_B     8'h14
`define MIRC_A_GRP_C     8'h18
`define MIRC_A_STAT      8'h1C
`define MIRC_A_CLR       8'h20
`define MIRC_A_IEN       8'h24

// ----------------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------------
`define MIRC_EDGE_RST    8'h03
`define MIRC_EDGE_MASK   8'h03
`define MIRC_CTRL_A_MASK 8'h7F
`define MIRC_CTRL_B_MASK 8'hFF
`define MIRC_CTRL_C_MASK 8'h11
`define MIRC_GRP_A_MASK  8'hFF
`define MIRC_GRP_B_MASK  8'h77
`define MIRC_GRP_C_MASK  8'h33
`define MIRC_ZERO8       8'h00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define MIRC_B_MASTER_EN 0
`define MIRC_B_PIN_EN    1
`define MIRC_B_CMP_EN    2
`define MIRC_B_G0_EN     3
`define MIRC_B_PIN_FLAG  4
`define MIRC_B_CMP_FLAG  5
`define MIRC_B_G0_FLAG   6
`define MIRC_B_G1_EN     0
`define MIRC_B_G2_EN     1
`define MIRC_B_ADC_EN    2
`define MIRC_B_TB0_EN    3
`define MIRC_B_G1_FLAG   4
`define MIRC_B_G2_FLAG   5
`define MIRC_B_ADC_FLAG  6
`define MIRC_B_TB0_FLAG  7
`define MIRC_B_TB1_EN    0
`define MIRC_B_TB1_FLAG  4

// status events: 0 pin, 1 cmp, 2 adc, 3 tb0, 4 tb1, 5..7 groups a..c
`define MIRC_NEV         8

`endif

// ==== verilog/mirc_edge_det.v ====
/*
  Pin synchroniser and edge qualifier for the external interrupt pin.
  Assumes the pin is asynchronous to core_clk.
*/
`timescale 1ns/1ps
module mirc_edge_det (
  input  wire       core_clk,
  input  wire       rst_b,
  input  wire       pin_in,
  input  wire [1:0] edge_sel,
  output reg        hit
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // ----------------------------------------------------------------------------
  // three stages; only s2/s3 disagreement is a change
  // ----------------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      hit  <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      hit  <= (edge_sel[0] & s2_r & ~s3_r) | (edge_sel[1] & ~s2_r & s3_r);
    end
  end
endmodule

// ==== verilog/mirc_core.v ====
/*
  Interrupt request controller: request flags, per-source and master enables,
  multi-function groups, external pin edge select, APB register slave.
  Assumes event inputs are one-cycle pulses on core_clk; the pin is asynchronous.
*/
// The APB slave port and the register offsets are this design's own decisions.
//
// Notes on behaviour
// - a source's trigger sets its flag in hardware; software may read or clear it
// - enabled pending request raises the service request to the processor
// - each source has an own enable gating its flag
// - flag value 1 means pending, 0 none; comparator flag at bit 5
// - pin flag set by pin activity on the selected edge
// - edge code 00 off, 01 rising, 10 falling, 11 both
// - timer, comparator, time base, low voltage, eeprom, converter sources
// - three group registers hold sub-flags and sub-enables
// - primary registers hold master enable, pin, comparator, converter, time bases, groups
// - unimplemented bits read as zero
`timescale 1ns/1ps
`include "mirc_map.vh"
module mirc_core (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire        ext_pin,
  input  wire        cmp_evt,
  input  wire        adc_evt,
  input  wire [1:0]  tb_evt,
  input  wire [2:0]  tmr_period_evt,
  input  wire [2:0]  tmr_cmp_a_evt,
  input  wire        tmr_cmp_b_evt,
  input  wire        low_volt_evt,
  input  wire        eeprom_evt,
  output reg         service_req,
  output reg         irq
);
  reg  [7:0] edge_r;
  reg  [7:0] ctrl_a_r;
  reg  [7:0] ctrl_b_r;
  reg  [7:0] ctrl_c_r;
  reg  [7:0] grp_a_r;
  reg  [7:0] grp_b_r;
  reg  [7:0] grp_c_r;
  reg  [7:0] stat_r;
  reg  [7:0] ien_r;
  reg  [7:0] ctrl_a_nxt;
  reg  [7:0] ctrl_b_nxt;
  reg  [7:0] ctrl_c_nxt;
  reg  [7:0] grp_a_nxt;
  reg  [7:0] grp_b_nxt;
  reg  [7:0] grp_c_nxt;
  reg  [7:0] stat_nxt;
  reg  [31:0] rdata_nxt;
  reg         err_nxt;
  wire        pin_hit;
  wire        wr_en;
  wire        acc;
  wire [7:0]  wd;
  wire        grp_a_act;
  wire        grp_b_act;
  wire        grp_c_act;
  wire [7:0]  events;
  wire        pend;

  assign acc = psel & penable & ~pready;
  assign wr_en = acc & pwrite;
  assign wd = pwdata[7:0];

  // ----------------------------------------------------------------------------
  // external pin
  // ----------------------------------------------------------------------------
  mirc_edge_det u_edge (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pin_in   (ext_pin),
    .edge_sel (edge_r[1:0]),
    .hit      (pin_hit)
  );

  // ----------------------------------------------------------------------------
  // group activity
  // ----------------------------------------------------------------------------
  // sub-flag and sub-enable
  assign grp_a_act = |(grp_a_r[7:4] & grp_a_r[3:0]);
  assign grp_b_act = |(grp_b_r[6:4] & grp_b_r[2:0]);
  assign grp_c_act = |(grp_c_r[5:4] & grp_c_r[1:0]);

  assign events = {grp_c_act, grp_b_act, grp_a_act, tb_evt[1], tb_evt[0],
                   adc_evt, cmp_evt, pin_hit};

  // ----------------------------------------------------------------------------
  // register next state; hardware set wins over software clear
  // ----------------------------------------------------------------------------
  always @* begin
    ctrl_a_nxt = ctrl_a_r;
    ctrl_b_nxt = ctrl_b_r;
    ctrl_c_nxt = ctrl_c_r;
    grp_a_nxt  = grp_a_r;
    grp_b_nxt  = grp_b_r;
    grp_c_nxt  = grp_c_r;
    stat_nxt   = stat_r;
    if (wr_en) begin
      case (paddr)
        `MIRC_A_CTRL_A: ctrl_a_nxt = wd & `MIRC_CTRL_A_MASK;
        `MIRC_A_CTRL_B: ctrl_b_nxt = wd & `MIRC_CTRL_B_MASK;
        `MIRC_A_CTRL_C: ctrl_c_nxt = wd & `MIRC_CTRL_C_MASK;
        `MIRC_A_GRP_A:  grp_a_nxt  = wd & `MIRC_GRP_A_MASK;
        `MIRC_A_GRP_B:  grp_b_nxt  = wd & `MIRC_GRP_B_MASK;
        `MIRC_A_GRP_C:  grp_c_nxt  = wd & `MIRC_GRP_C_MASK;
        `MIRC_A_CLR:    stat_nxt   = stat_r & ~wd;
        default: begin
        end
      endcase
    end
    if (pin_hit)
      ctrl_a_nxt[`MIRC_B_PIN_FLAG] = 1'b1;
    if (cmp_evt)
      ctrl_a_nxt[`MIRC_B_CMP_FLAG] = 1'b1;
    if (adc_evt)
      ctrl_b_nxt[`MIRC_B_ADC_FLAG] = 1'b1;
    if (tb_evt[0])
      ctrl_b_nxt[`MIRC_B_TB0_FLAG] = 1'b1;
    if (tb_evt[1])
      ctrl_c_nxt[`MIRC_B_TB1_FLAG] = 1'b1;
    grp_a_nxt[7:4] = grp_a_nxt[7:4] | {tmr_cmp_a_evt[1], tmr_period_evt[1],
                                        tmr_cmp_a_evt[0], tmr_period_evt[0]};
    grp_b_nxt[6:4] = grp_b_nxt[6:4] | {tmr_cmp_b_evt, tmr_cmp_a_evt[2],
                                        tmr_period_evt[2]};
    grp_c_nxt[5:4] = grp_c_nxt[5:4] | {eeprom_evt, low_volt_evt};
    if (grp_a_act)
      ctrl_a_nxt[`MIRC_B_G0_FLAG] = 1'b1;
    if (grp_b_act)
      ctrl_b_nxt[`MIRC_B_G1_FLAG] = 1'b1;
    if (grp_c_act)
      ctrl_b_nxt[`MIRC_B_G2_FLAG] = 1'b1;
    stat_nxt = stat_nxt | events;
  end

  // ----------------------------------------------------------------------------
  // read mux; unmapped addresses give pslverr
  // ----------------------------------------------------------------------------
  always @* begin
    rdata_nxt = 32'h00000000;
    err_nxt   = 1'b0;
    case (paddr)
      `MIRC_A_EDGE:   rdata_nxt[7:0] = edge_r & `MIRC_EDGE_MASK;
      `MIRC_A_CTRL_A: rdata_nxt[7:0] = ctrl_a_r;
      `MIRC_A_CTRL_B: rdata_nxt[7:0] = ctrl_b_r;
      `MIRC_A_CTRL_C: rdata_nxt[7:0] = ctrl_c_r;
      `MIRC_A_GRP_A:  rdata_nxt[7:0] = grp_a_r;
      `MIRC_A_GRP_B:  rdata_nxt[7:0] = grp_b_r;
      `MIRC_A_GRP_C:  rdata_nxt[7:0] = grp_c_r;
      `MIRC_A_STAT:   rdata_nxt[7:0] = stat_r;
      `MIRC_A_CLR:    rdata_nxt[7:0] = `MIRC_ZERO8;
      `MIRC_A_IEN:    rdata_nxt[7:0] = ien_r;
      default:        err_nxt = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------------------
  // service request
  // ----------------------------------------------------------------------------
  // per-source enable
  assign pend =
    (ctrl_a_r[`MIRC_B_PIN_FLAG] & ctrl_a_r[`MIRC_B_PIN_EN]) |
    (ctrl_a_r[`MIRC_B_CMP_FLAG] & ctrl_a_r[`MIRC_B_CMP_EN]) |
    (ctrl_a_r[`MIRC_B_G0_FLAG]  & ctrl_a_r[`MIRC_B_G0_EN])  |
    (ctrl_b_r[`MIRC_B_G1_FLAG]  & ctrl_b_r[`MIRC_B_G1_EN])  |
    (ctrl_b_r[`MIRC_B_G2_FLAG]  & ctrl_b_r[`MIRC_B_G2_EN])  |
    (ctrl_b_r[`MIRC_B_ADC_FLAG] & ctrl_b_r[`MIRC_B_ADC_EN]) |
    (ctrl_b_r[`MIRC_B_TB0_FLAG] & ctrl_b_r[`MIRC_B_TB0_EN]) |
    (ctrl_c_r[`MIRC_B_TB1_FLAG] & ctrl_c_r[`MIRC_B_TB1_EN]);

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_r      <= `MIRC_EDGE_RST;
      ctrl_a_r    <= `MIRC_ZERO8;
      ctrl_b_r    <= `MIRC_ZERO8;
      ctrl_c_r    <= `MIRC_ZERO8;
      grp_a_r     <= `MIRC_ZERO8;
      grp_b_r     <= `MIRC_ZERO8;
      grp_c_r     <= `MIRC_ZERO8;
      stat_r      <= `MIRC_ZERO8;
      ien_r       <= `MIRC_ZERO8;
      pready      <= 1'b0;
      prdata      <= 32'h00000000;
      pslverr     <= 1'b0;
      service_req <= 1'b0;
      irq         <= 1'b0;
    end else begin
      ctrl_a_r <= ctrl_a_nxt;
      ctrl_b_r <= ctrl_b_nxt;
      ctrl_c_r <= ctrl_c_nxt;
      grp_a_r  <= grp_a_nxt;
      grp_b_r  <= grp_b_nxt;
      grp_c_r  <= grp_c_nxt;
      stat_r   <= stat_nxt;
      if (wr_en && paddr == `MIRC_A_EDGE)
        edge_r <= wd & `MIRC_EDGE_MASK;
      if (wr_en && paddr == `MIRC_A_IEN)
        ien_r <= wd;
      // one wait state: answer in the cycle after the access phase starts
      pready  <= acc;
      pslverr <= acc & err_nxt;
      if (acc && !pwrite)
        prdata <= rdata_nxt;
      service_req <= pend & ctrl_a_r[`MIRC_B_MASTER_EN];
      irq <= |(stat_r & ien_r);
    end
  end
endmodule

// ==== verification/mirc_checker.sv ====
/*
  Port-level assertions for mirc_core.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
module mirc_checker (
  input wire        core_clk,
  input wire        rst_b,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        cmp_evt,
  input wire        service_req
);
  // shadows of master enable and comparator flag
  reg  master_r;
  reg  cmp_flag_r;
  wire ctrl_a_wr = psel && penable && !pready && pwrite && paddr == 8'h04;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      master_r   <= 1'b0;
      cmp_flag_r <= 1'b0;
    end else begin
      if (ctrl_a_wr)
        master_r <= pwdata[0];
      if (ctrl_a_wr)
        cmp_flag_r <= pwdata[5] | cmp_evt;
      else if (cmp_evt)
        cmp_flag_r <= 1'b1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  AST_ANSWER_NEXT: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after access");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_HI_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_EDGE_RSVD: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata[7:2] == 6'h0)
    else $error("edge select unused bits set");
  AST_UNMAPPED: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_CMP_BIT5: assert property (pready && !pwrite && paddr == 8'h04 |-> prdata[5] == $past(cmp_flag_r))
    else $error("comparator flag wrong");
  AST_MASTER_OFF: assert property (!master_r && !$past(master_r) |-> !service_req)
    else $error("service without master enable");
endmodule
bind mirc_core mirc_checker mirc_checker_i (.core_clk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .prdata, .pslverr, .cmp_evt, .service_req);

// ==== verification/mirc_evt_src.sv ====
/*
  Peripheral event model: one-cycle pulses and the external pin.
  Assumes the bench calls its tasks between clock edges.
*/
`timescale 1ns/1ps
module mirc_evt_src (
  input  wire       core_clk,
  output wire       cmp_evt,
  output wire       adc_evt,
  output wire [1:0] tb_evt,
  output wire [2:0] tmr_period_evt,
  output wire [2:0] tmr_cmp_a_evt,
  output wire       tmr_cmp_b_evt,
  output wire       low_volt_evt,
  output wire       eeprom_evt,
  output reg        ext_pin
);
  reg [12:0] ev_r;
  assign {eeprom_evt, low_volt_evt, tmr_cmp_b_evt, tmr_cmp_a_evt, tmr_period_evt, tb_evt,
          adc_evt, cmp_evt} = ev_r;
  initial begin
    ev_r    = 13'h0000;
    ext_pin = 1'b0;
  end
  task pulse(input [12:0] v);
    begin
      @(posedge core_clk) ev_r <= v;
      @(posedge core_clk) ev_r <= 13'h0000;
    end
  endtask
  task pin(input v);
    @(posedge core_clk) ext_pin <= v;
  endtask
endmodule

// ==== verification/test_mcu_interrupt_request_control.sv ====
/*
  Self-checking bench for mirc_core.
  Assumes the checker binds itself and mirc_evt_src stands for the peripherals.
*/
`timescale 1ns/1ps
`include "mirc_map.vh"
module test_mcu_interrupt_request_control;
  reg         core_clk, rst_b, psel, penable, pwrite, e;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, q;
  wire        pready, pslverr, service_req, irq, ext_pin, cmp_evt, adc_evt;
  wire        tmr_cmp_b_evt, low_volt_evt, eeprom_evt;
  wire [31:0] prdata;
  wire [1:0]  tb_evt;
  wire [2:0]  tmr_period_evt, tmr_cmp_a_evt;
  integer     err_total, n_tests;
  mirc_core mirc_core_i (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .ext_pin, .cmp_evt, .adc_evt, .tb_evt, .tmr_period_evt,
    .tmr_cmp_a_evt, .tmr_cmp_b_evt, .low_volt_evt, .eeprom_evt, .service_req, .irq);
  mirc_evt_src mirc_evt_src_i (.core_clk, .cmp_evt, .adc_evt, .tb_evt, .tmr_period_evt,
    .tmr_cmp_a_evt, .tmr_cmp_b_evt, .low_volt_evt, .eeprom_evt, .ext_pin);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // ---------------------------------
  // bus and compare tasks
  // ---------------------------------
  task complete_run;
    begin
      $display("mismatches %0d comparisons %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] x);
    begin
      n_tests = n_tests + 1;
      if (g !== x) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge core_clk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge core_clk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: bus hang", $time);
        complete_run;
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input [7:0] a, input [31:0] x);
    begin
      apb(1'b0, a, 32'h0);
      chk(q, x);
    end
  endtask
  // irq in bit 1, service request in bit 0
  task lvl(input [1:0] x);
    begin
      repeat (2) @(posedge core_clk);
      chk({30'h0, irq, service_req}, {30'h0, x});
    end
  endtask
  // ---------------------------------
  // scenarios
  // ---------------------------------
  task t_reset;
    integer i;
    begin
      rd(`MIRC_A_EDGE, 32'h3);
      for (i = 4; i < 40; i = i + 4)
        rd(i[7:0], 32'h0);
      apb(1'b0, 8'h28, 32'h0);
      chk({31'h0, e}, 32'h1);
      wr(`MIRC_A_EDGE, 32'hFF);
      rd(`MIRC_A_EDGE, 32'h3);
      lvl(2'b00);
    end
  endtask
  task t_cmp;
    begin
      wr(`MIRC_A_CTRL_A, 32'h04);
      mirc_evt_src_i.pulse(13'h0001);
      rd(`MIRC_A_CTRL_A, 32'h24);
      lvl(2'b00);
      wr(`MIRC_A_CTRL_A, 32'h21);
      lvl(2'b00);
      wr(`MIRC_A_CTRL_A, 32'h25);
      lvl(2'b01);
      wr(`MIRC_A_CTRL_A, 32'h05);
      rd(`MIRC_A_CTRL_A, 32'h05);
      lvl(2'b00);
    end
  endtask
  task t_edge;
    integer c;
    begin
      for (c = 0; c < 4; c = c + 1) begin
        wr(`MIRC_A_EDGE, c);
        wr(`MIRC_A_CTRL_A, 32'h0);
        mirc_evt_src_i.pin(1'b1);
        repeat (8) @(posedge core_clk);
        rd(`MIRC_A_CTRL_A, c[0] ? 32'h10 : 32'h0);
        wr(`MIRC_A_CTRL_A, 32'h0);
        mirc_evt_src_i.pin(1'b0);
        repeat (8) @(posedge core_clk);
        rd(`MIRC_A_CTRL_A, c[1] ? 32'h10 : 32'h0);
      end
    end
  endtask
  task t_grp;
    begin
      wr(`MIRC_A_GRP_A, 32'h0F);
      wr(`MIRC_A_CTRL_A, 32'h09);
      mirc_evt_src_i.pulse(13'h0010);
      rd(`MIRC_A_GRP_A, 32'h1F);
      rd(`MIRC_A_CTRL_A, 32'h49);
      lvl(2'b01);
      wr(`MIRC_A_GRP_A, 32'h0);
      wr(`MIRC_A_CTRL_A, 32'h09);
      mirc_evt_src_i.pulse(13'h0010);
      rd(`MIRC_A_GRP_A, 32'h10);
      rd(`MIRC_A_CTRL_A, 32'h09);
      wr(`MIRC_A_GRP_A, 32'h0);
      wr(`MIRC_A_CTRL_A, 32'h0);
    end
  endtask
  // mid-run reset: registers must return to their power-on values
  task t_rst;
    begin
      wr(`MIRC_A_EDGE, 32'h0);
      wr(`MIRC_A_CTRL_A, 32'h0F);
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      rd(`MIRC_A_EDGE, 32'h3);
      rd(`MIRC_A_CTRL_A, 32'h0);
      lvl(2'b00);
    end
  endtask
  // group b is implemented on this variant, so software may use it here
  task t_all;
    begin
      wr(`MIRC_A_CLR, 32'hFF);
      wr(`MIRC_A_GRP_A, 32'h0F);
      wr(`MIRC_A_GRP_B, 32'h07);
      wr(`MIRC_A_GRP_C, 32'h03);
      mirc_evt_src_i.pulse(13'h1FFF);
      rd(`MIRC_A_STAT, 32'hFE);
      rd(`MIRC_A_GRP_A, 32'hFF);
      rd(`MIRC_A_GRP_B, 32'h77);
      rd(`MIRC_A_GRP_C, 32'h33);
      rd(`MIRC_A_CTRL_B, 32'hF0);
      rd(`MIRC_A_CTRL_C, 32'h10);
      lvl(2'b00);
      wr(`MIRC_A_IEN, 32'h80);
      lvl(2'b10);
      wr(`MIRC_A_GRP_C, 32'h0);
      wr(`MIRC_A_CLR, 32'h80);
      rd(`MIRC_A_STAT, 32'h7E);
      lvl(2'b00);
    end
  endtask
  initial begin
    err_total = 0;
    n_tests = 0;
    rst_b = 1'b0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset;
    t_cmp;
    t_edge;
    t_grp;
    t_all;
    t_rst;
    complete_run;
  end
endmodule
